/* nfc_core.sv */
// Numeric format converter datapath: float to 16/32-bit integer with
// saturation, and binary to packed decimal with operand checking.
// Assumes the sequencer holds operands steady and pulses op_en for one clock.
//
// Summary of operation
// RULE1: With enable valid, a float source converts to a signed 16-bit integer written to the destination.
// RULE2: For both float conversions the zero flag is set when the integer result is zero.
// RULE3: For both float conversions the borrow flag is set when a nonzero fraction is dropped and the result does not saturate.
// RULE4: In the 16-bit float conversion a source above 32767 gives exactly 32767 and sets carry.
// RULE5: In the 16-bit float conversion a source below -32768 gives exactly -32768 and sets carry.
// RULE6: With enable valid, a float source converts to a signed 32-bit integer written to the destination.
// RULE7: Carry is set when a 32-bit float conversion result falls outside the signed 32-bit range.
// RULE8: In the 32-bit float conversion a source above 2147483647 gives exactly 2147483647.
// RULE9: In the 32-bit float conversion a source below -2147483648 gives exactly -2147483648 with carry set.
// RULE10: With enable valid, a 16-bit word converts to four packed decimal digits in the destination.
// RULE11: A 16-bit decimal source above 9999 raises an operand error and leaves the destination unchanged.
// RULE12: With enable valid, a 32-bit word converts to eight packed decimal digits in the destination.
// RULE13: A 32-bit decimal source above 99999999 raises an operand error and leaves the destination unchanged.
// RULE14: The dropped fraction truncates toward zero, so 10000.5 gives 10000.
// RULE15: Operands come with a one-clock enable; results and flags change on that edge only and hold otherwise.
`timescale 1ns/1ps
module nfc_core
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Instruction request
   input  wire logic        op_en,
   input  wire logic [1:0]  op_sel,
   input  wire logic [31:0] src_in,
   // Results and flags
   output logic      [31:0] dst_r,
   output logic             zero_r,
   output logic             borrow_r,
   output logic             carry_r,
   output logic             opnd_err_r
);

   // ----------------------------------------------------------------------
   // Packed-decimal encoder
   // ----------------------------------------------------------------------
   // Shift-and-add-three; only valid for sources up to eight digits, which
   // the operand check guarantees before the result is used.
   function automatic logic [31:0] nfc_to_decimal(input logic [31:0] bin);
      logic [63:0] acc;
      acc = {32'h00000000, bin};
      for (int i = 0; i < 32; i++)
      begin
         for (int d = 0; d < 8; d++)
         begin
            if (acc[32 + 4*d +: 4] > 4'h4)
            begin
               acc[32 + 4*d +: 4] = acc[32 + 4*d +: 4] + 4'h3;
            end
         end
         acc = {acc[62:0], 1'b0};
      end
      return acc[63:32];
   endfunction

   // ----------------------------------------------------------------------
   // Float to integer datapath
   // ----------------------------------------------------------------------
   logic        f_sign;
   logic [7:0]  f_exp;
   logic [55:0] f_shifted;
   logic [32:0] f_mag;
   logic        f_frac;
   logic        f_huge;
   logic        f_ovf;
   logic [32:0] lim_pos;
   logic [32:0] lim_neg;
   logic [31:0] sat_max;
   logic [31:0] sat_min;
   logic [31:0] f_result;
   logic [7:0]  shift_amt;

   // Align the hidden-one mantissa so the binary point sits at bit 23
   always_comb
   begin
      f_sign    = src_in[nfc_pkg::SIGN_POS];
      f_exp     = src_in[nfc_pkg::EXP_MSB:nfc_pkg::EXP_LSB];
      f_huge    = (f_exp >= nfc_pkg::EXP_HUGE);
      shift_amt = f_exp - nfc_pkg::EXP_BIAS;
      f_shifted = {32'h00000000, 1'b1, src_in[nfc_pkg::MANT_MSB:0]} << shift_amt[4:0];
      if (f_exp < nfc_pkg::EXP_BIAS)
      begin
         // Magnitude below one: integer part is zero, any nonzero bits are fraction
         f_mag  = 33'h000000000;                                         // RULE14
         f_frac = (src_in[nfc_pkg::EXP_MSB:0] != 31'h00000000);          // RULE3
      end
      else
      begin
         f_mag  = f_shifted[55:23];                                      // RULE14
         f_frac = (f_shifted[22:0] != 23'h000000);                       // RULE3
      end
   end

   // Width-dependent limits; the negative side reaches one further
   always_comb
   begin
      if (op_sel == nfc_pkg::OP_FLOAT_TO_WORD)
      begin
         lim_pos = nfc_pkg::WORD_POS_LIMIT;
         lim_neg = nfc_pkg::WORD_NEG_LIMIT;
         sat_max = nfc_pkg::WORD_MAX;
         sat_min = nfc_pkg::WORD_MIN;
      end
      else
      begin
         lim_pos = nfc_pkg::LONG_POS_LIMIT;
         lim_neg = nfc_pkg::LONG_NEG_LIMIT;
         sat_max = nfc_pkg::LONG_MAX;
         sat_min = nfc_pkg::LONG_MIN;
      end
      // Infinity and NaN fall into the huge range and clamp by sign; a dropped
      // fraction on the limit itself still lies beyond it, so it clamps as well
      f_ovf = f_huge
              || (f_sign ? (f_mag > lim_neg) || (f_mag == lim_neg && f_frac)
                         : (f_mag > lim_pos) || (f_mag == lim_pos && f_frac)); // RULE4 RULE5 RULE7
      if (f_ovf)
      begin
         f_result = f_sign ? sat_min : sat_max;                          // RULE4 RULE5 RULE8 RULE9
      end
      else
      begin
         f_result = f_sign ? (32'h00000000 - f_mag[31:0]) : f_mag[31:0]; // RULE1 RULE6
      end
   end

   // ----------------------------------------------------------------------
   // Result and flag registers
   // ----------------------------------------------------------------------
   logic [31:0] dst_nxt;
   logic        zero_nxt;
   logic        borrow_nxt;
   logic        carry_nxt;
   logic        opnd_err_nxt;
   logic [31:0] word_src;

   // Next values; everything holds unless the one-clock enable is present
   always_comb
   begin
      dst_nxt      = dst_r;
      zero_nxt     = zero_r;
      borrow_nxt   = borrow_r;
      carry_nxt    = carry_r;
      opnd_err_nxt = opnd_err_r;
      word_src     = {16'h0000, src_in[15:0]};
      if (op_en)                                                         // RULE15
      begin
         unique case (op_sel)
            nfc_pkg::OP_FLOAT_TO_WORD,
            nfc_pkg::OP_FLOAT_TO_LONG:
            begin
               dst_nxt      = f_result;                                  // RULE1 RULE6
               zero_nxt     = (f_result == 32'h00000000);                // RULE2
               borrow_nxt   = f_frac && !f_ovf;                          // RULE3
               carry_nxt    = f_ovf;                                     // RULE4 RULE5 RULE7 RULE9
               opnd_err_nxt = 1'b0;
            end
            nfc_pkg::OP_WORD_TO_PACKED_DECIMAL:
            begin
               // Out-of-range source skips the write entirely
               opnd_err_nxt = (word_src > nfc_pkg::WORD_DECIMAL_LIMIT);  // RULE11
               if (!opnd_err_nxt)
               begin
                  dst_nxt = nfc_to_decimal(word_src);                    // RULE10
               end
            end
            nfc_pkg::OP_LONG_TO_PACKED_DECIMAL:
            begin
               opnd_err_nxt = (src_in > nfc_pkg::LONG_DECIMAL_LIMIT);    // RULE13
               if (!opnd_err_nxt)
               begin
                  dst_nxt = nfc_to_decimal(src_in);                      // RULE12
               end
            end
         endcase
      end
   end

   // Register stage; outputs come straight from these flops
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         dst_r      <= nfc_pkg::DEST_RESET;
         zero_r     <= 1'b0;
         borrow_r   <= 1'b0;
         carry_r    <= 1'b0;
         opnd_err_r <= 1'b0;
      end
      else
      begin
         dst_r      <= dst_nxt;
         zero_r     <= zero_nxt;
         borrow_r   <= borrow_nxt;
         carry_r    <= carry_nxt;
         opnd_err_r <= opnd_err_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   idle_hold_a: assert property (!op_en |=> $stable(dst_r) && $stable(carry_r) && $stable(opnd_err_r)
      && $stable(zero_r) && $stable(borrow_r)) // RULE15
      else $error("outputs moved without enable");
   sat_word_pos_a: assert property (op_en && op_sel == 2'h0 && !src_in[31] && src_in[30:23] >= 8'h8E
      |=> dst_r == 32'h00007FFF && carry_r) // RULE4
      else $error("16-bit positive saturation wrong");
   sat_word_neg_a: assert property (op_en && op_sel == 2'h0 && src_in[31] && src_in[30:23] >= 8'h8F
      |=> dst_r == 32'hFFFF8000 && carry_r) // RULE5
      else $error("16-bit negative saturation wrong");
   sat_long_pos_a: assert property (op_en && op_sel == 2'h1 && !src_in[31] && src_in[30:23] >= 8'h9E
      |=> dst_r == 32'h7FFFFFFF && carry_r) // RULE8
      else $error("32-bit positive saturation wrong");
   sat_long_neg_a: assert property (op_en && op_sel == 2'h1 && src_in[31] && src_in[30:23] >= 8'h9F
      |=> dst_r == 32'h80000000 && carry_r) // RULE9
      else $error("32-bit negative saturation wrong");
   small_frac_a: assert property (op_en && !op_sel[1] && src_in[30:23] < 8'h7F && src_in[30:0] != 31'h0
      |=> dst_r == 32'h0 && zero_r && borrow_r && !carry_r) // RULE2
      else $error("fraction below one mishandled");
   exact_long_a: assert property (op_en && op_sel == 2'h1 && src_in == 32'h47C35000
      |=> dst_r == 32'h000186A0 && !borrow_r && !zero_r) // RULE6
      else $error("exact 100000.0 conversion wrong");
   trunc_word_a: assert property (op_en && op_sel == 2'h0 && src_in == 32'h461C4200
      |=> dst_r == 32'h00002710 && borrow_r && !carry_r) // RULE14
      else $error("10000.5 not truncated to 10000");
   dec_word_err_a: assert property (op_en && op_sel == 2'h2 && src_in[15:0] > 16'h270F
      |=> opnd_err_r && dst_r == $past(dst_r)) // RULE11
      else $error("16-bit decimal range error missed");
   dec_long_err_a: assert property (op_en && op_sel == 2'h3 && src_in > 32'h05F5E0FF
      |=> opnd_err_r && dst_r == $past(dst_r)) // RULE13
      else $error("32-bit decimal range error missed");
   dec_word_ok_a: assert property (op_en && op_sel == 2'h2 && src_in[15:0] <= 16'h270F
      |=> !opnd_err_r && dst_r[31:16] == 16'h0 && 32'(dst_r[3:0]) == 32'($past(src_in[15:0])) % 32'h0000000A) // RULE10
      else $error("16-bit decimal digits wrong");
   dec_long_ok_a: assert property (op_en && op_sel == 2'h3 && src_in <= 32'h05F5E0FF
      |=> !opnd_err_r && 32'(dst_r[31:28]) == $past(src_in) / 32'h00989680) // RULE12
      else $error("32-bit decimal top digit wrong");

endmodule

/* nfc_pkg.sv */
// Constants for the numeric format converter: operation codes, float field
// layout, saturation limits and packed-decimal source limits.
// Assumes IEEE single-precision sources and two's complement destinations.
package nfc_pkg;

   // ----------------------------------------------------------------------
   // Operation select codes
   // ----------------------------------------------------------------------
   localparam logic [1:0]  OP_FLOAT_TO_WORD             = 2'h0;
   localparam logic [1:0]  OP_FLOAT_TO_LONG             = 2'h1;
   localparam logic [1:0]  OP_WORD_TO_PACKED_DECIMAL    = 2'h2;
   localparam logic [1:0]  OP_LONG_TO_PACKED_DECIMAL    = 2'h3;

   // ----------------------------------------------------------------------
   // Single-precision field layout
   // ----------------------------------------------------------------------
   localparam int          SIGN_POS                     = 31;
   localparam int          EXP_MSB                      = 30;
   localparam int          EXP_LSB                      = 23;
   localparam int          MANT_MSB                     = 22;
   localparam logic [7:0]  EXP_BIAS                     = 8'h7F;
   localparam logic [7:0]  EXP_HUGE                     = 8'h9F;  // Shift of 32 or more
   localparam logic [4:0]  EXP_SHIFT_W                  = 5'h1F;  // Unused, kept for width intent

   // ----------------------------------------------------------------------
   // Saturation limits (magnitudes and clamped results)
   // ----------------------------------------------------------------------
   localparam logic [32:0] WORD_POS_LIMIT               = 33'h000007FFF;  // 32767
   localparam logic [32:0] WORD_NEG_LIMIT               = 33'h000008000;  // 32768
   localparam logic [32:0] LONG_POS_LIMIT               = 33'h07FFFFFFF;  // 2147483647
   localparam logic [32:0] LONG_NEG_LIMIT               = 33'h080000000;  // 2147483648
   localparam logic [31:0] WORD_MAX                     = 32'h00007FFF;
   localparam logic [31:0] WORD_MIN                     = 32'hFFFF8000;
   localparam logic [31:0] LONG_MAX                     = 32'h7FFFFFFF;
   localparam logic [31:0] LONG_MIN                     = 32'h80000000;

   // ----------------------------------------------------------------------
   // Packed-decimal source limits
   // ----------------------------------------------------------------------
   localparam logic [31:0] WORD_DECIMAL_LIMIT           = 32'h0000270F;  // 9999
   localparam logic [31:0] LONG_DECIMAL_LIMIT           = 32'h05F5E0FF;  // 99999999

   // ----------------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------------
   localparam logic [31:0] DEST_RESET                   = 32'h00000000;

endpackage

/* nfc_seq_model.sv */
// Behavioural model of the instruction sequencer that feeds the converter.
// Assumes a free-running clk; every request is launched at a falling edge.
`timescale 1ns/1ps
module nfc_seq_model
(
   // Clock
   input  wire logic        clk,
   // Request to the converter
   output logic             op_en,
   output logic [1:0]       op_sel,
   output logic [31:0]      src_in
);
   // -----------------------------------------------------------------
   // Idle state
   // -----------------------------------------------------------------
   // Quiet bus at time zero
   initial
   begin
      op_en  = 1'b0;
      op_sel = 2'h0;
      src_in = 32'h00000000;
   end

   // -----------------------------------------------------------------
   // Request launch
   // -----------------------------------------------------------------
   // One-clock enable pulse; operands are inverted once released,
   // so a converter that samples late sees garbage, not a held value
   task automatic issue(input logic [1:0] sel, input logic [31:0] src);
   begin
      @(negedge clk);
      op_en  = 1'b1;
      op_sel = sel;
      src_in = src;
      @(negedge clk);
      op_en  = 1'b0;
      op_sel = ~sel;
      src_in = ~src;
   end
   endtask
endmodule

/* testbench.sv */
// Self-checking bench for the numeric format converter.
// Assumes the sequencer model issues each request; results are read
// one falling edge after the enable pulse.
`timescale 1ns/1ps
module testbench;
   // -----------------------------------------------------------------
   // Signals and counters
   // -----------------------------------------------------------------
   logic        clk;
   logic        sys_rst;
   logic        op_en;
   logic [1:0]  op_sel;
   logic [31:0] src_in;
   logic [31:0] dst_r;
   logic        zero_r;
   logic        borrow_r;
   logic        carry_r;
   logic        opnd_err_r;
   int          err_count;
   int          tests_run;

   nfc_core u_dut (.clk(clk), .sys_rst(sys_rst), .op_en(op_en), .op_sel(op_sel), .src_in(src_in),
                   .dst_r(dst_r), .zero_r(zero_r), .borrow_r(borrow_r), .carry_r(carry_r),
                   .opnd_err_r(opnd_err_r));
   nfc_seq_model u_seq (.clk(clk), .op_en(op_en), .op_sel(op_sel), .src_in(src_in));

   // 100 ns clock
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   // Flags packed as zero, borrow, carry, operand error
   task automatic expect_out(input logic [31:0] d, input logic [3:0] f);
   begin
      tests_run++;
      if ({dst_r, zero_r, borrow_r, carry_r, opnd_err_r} !== {d, f})
      begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time,
                  {dst_r, zero_r, borrow_r, carry_r, opnd_err_r}, {d, f});
      end
   end
   endtask

   task automatic run(input logic [1:0] s, input logic [31:0] v, input logic [31:0] d, input logic [3:0] f);
   begin
      u_seq.issue(s, v);
      expect_out(d, f);
   end
   endtask

   task automatic summarize();
   begin
      $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   end
   endtask

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   // Word conversions: truncation, zero, both clamps
   task automatic float_word_conv();
   begin
      run(2'h0, 32'h461C4200, 32'h00002710, 4'h4);
      run(2'h0, 32'h00000000, 32'h00000000, 4'h8);
      run(2'h0, 32'h471C4000, 32'h00007FFF, 4'h2);
      run(2'h0, 32'hC71C4000, 32'hFFFF8000, 4'h2);
      run(2'h0, 32'h46FFFF00, 32'h00007FFF, 4'h2);
      run(2'h0, 32'hC7000080, 32'hFFFF8000, 4'h2);
      run(2'h0, 32'hC7000000, 32'hFFFF8000, 4'h0);
      run(2'h0, 32'hC7800000, 32'hFFFF8000, 4'h2);
      run(2'h0, 32'h3F000000, 32'h00000000, 4'hC);
   end
   endtask

   // Long conversions: fraction, clamps, negative truncation, minus zero
   task automatic float_long_conv();
   begin
      run(2'h1, 32'h47C35040, 32'h000186A0, 4'h4);
      run(2'h1, 32'h47C35000, 32'h000186A0, 4'h0);
      run(2'h1, 32'h4F800000, 32'h7FFFFFFF, 4'h2);
      run(2'h1, 32'hCF800000, 32'h80000000, 4'h2);
      run(2'h1, 32'hBFC00000, 32'hFFFFFFFF, 4'h4);
      run(2'h1, 32'h80000000, 32'h00000000, 4'h8);
   end
   endtask

   // Four digits; a refused source keeps the old result and other flags, setting operand error
   task automatic dec_word_conv();
   begin
      run(2'h2, 32'h00000D05, 32'h00003333, 4'h8);
      run(2'h2, 32'h0000270F, 32'h00009999, 4'h8);
      run(2'h2, 32'h00002710, 32'h00009999, 4'h9);
   end
   endtask

   // Eight digits, boundary and first refused value
   task automatic dec_long_conv();
   begin
      run(2'h3, 32'h03F940AA, 32'h66666666, 4'h8);
      run(2'h3, 32'h05F5E0FF, 32'h99999999, 4'h8);
      run(2'h3, 32'h05F5E100, 32'h99999999, 4'h9);
   end
   endtask

   // Outputs must hold while the enable is low and operands wander
   task automatic hold_check();
   begin
      run(2'h0, 32'h461C4200, 32'h00002710, 4'h4);
      repeat (3) @(negedge clk);
      expect_out(32'h00002710, 4'h4);
   end
   endtask

   // -----------------------------------------------------------------
   // Main sequence and watchdog
   // -----------------------------------------------------------------
   initial
   begin
      err_count = 0;
      tests_run = 0;
      sys_rst   = 1'b1;
      repeat (4) @(negedge clk);
      sys_rst   = 1'b0;
      expect_out(32'h00000000, 4'h0);
      float_word_conv();
      float_long_conv();
      dec_word_conv();
      dec_long_conv();
      hold_check();
      summarize();
   end

   // Cuts a hang short well beyond the normal run length
   initial
   begin
      #2000000;
      err_count++;
      summarize();
   end
endmodule
